// ---- design/amf_params.svh ----
/*
 * Constants for the amplifier mode and fault control block: timing figures,
 * reset values and the gate drive levels that switch a transistor off.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef AMF_PARAMS_SVH
`define AMF_PARAMS_SVH

// ============================================================
// Timing
`define AMF_CLK_PERIOD_NS 100
`define AMF_DEAD_TIME_NS 40
`define AMF_CNT_W 4

// ============================================================
// Reset and off levels
`define AMF_FAULT_RST 1'h0
`define AMF_PGATE_OFF 1'h1
`define AMF_NGATE_OFF 1'h0
`define AMF_SYNC_RST 7'h00

`endif

// ---- design/amf_pkg.sv ----
/*
 * Types shared by the amplifier mode and fault control block.
 * Assumes amf_params.svh is on the include path.
 */
package amf_pkg;

	// ============================================================
	// Operating modes
	typedef enum logic [1:0] {
		AMF_MODE_SLEEP = 2'b00,
		AMF_MODE_MUTE = 2'b01,
		AMF_MODE_RUN = 2'b10
	} amf_mode_t;

	// ============================================================
	// Half bridge sequencer states
	typedef enum logic [1:0] {
		AMF_HB_OFF = 2'b00,
		AMF_HB_DEAD = 2'b01,
		AMF_HB_HIGH = 2'b10,
		AMF_HB_LOW = 2'b11
	} amf_hb_state_t;

	// ============================================================
	// Gate pair of one bridge half
	typedef struct packed {
		logic p_gate;
		logic n_gate;
	} amf_gate_t;

	// Sense conditions, 1 means fail
	typedef struct packed {
		logic temp;
		logic right_neg;
		logic right_pos;
		logic left_neg;
		logic left_pos;
	} amf_sense_t;

endpackage

// ---- design/amf_half_bridge.sv ----
/*
 * One bridge half: turns a high side on request into a P and N gate pair
 * with an off interval at every transition.
 * Assumes drive_high_on comes from logic on clk; enable is registered upstream.
 */
`timescale 1ns/1ps
`default_nettype none
`include "amf_params.svh"

module amf_half_bridge #(
	parameter int CNT_W = `AMF_CNT_W,
	parameter logic [CNT_W-1:0] DEAD_CYC = CNT_W'(1)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic enable,
	input wire logic drive_high_on,
	// Gates
	output amf_pkg::amf_gate_t gate
);
	import amf_pkg::*;

	typedef struct packed {
		amf_hb_state_t st;
		logic [CNT_W-1:0] cnt;
		amf_gate_t gate;
	} amf_hb_reg_t;

	amf_hb_reg_t s_r;
	amf_hb_reg_t s_nxt;

	// ============================================================
	// Sequencer
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			AMF_HB_OFF: begin
				s_nxt.cnt = DEAD_CYC - 1'b1;
				if (enable) begin
					s_nxt.st = AMF_HB_DEAD;
				end
			end
			AMF_HB_DEAD: begin
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end else begin
					s_nxt.st = drive_high_on ? AMF_HB_HIGH : AMF_HB_LOW;
				end
			end
			AMF_HB_HIGH: begin
				if (!drive_high_on) begin
					s_nxt.st = AMF_HB_DEAD;
					s_nxt.cnt = DEAD_CYC - 1'b1;
				end
			end
			AMF_HB_LOW: begin
				if (drive_high_on) begin
					s_nxt.st = AMF_HB_DEAD;
					s_nxt.cnt = DEAD_CYC - 1'b1;
				end
			end
			default: begin
				s_nxt.st = AMF_HB_OFF;
			end
		endcase
		// Off wins at once; no off interval needed when both go off
		if (!enable) begin
			s_nxt.st = AMF_HB_OFF;
		end
		// Gates follow the next state so they are registered
		case (s_nxt.st)
			AMF_HB_HIGH: begin
				s_nxt.gate.p_gate = ~`AMF_PGATE_OFF;
				s_nxt.gate.n_gate = `AMF_NGATE_OFF;
			end
			AMF_HB_LOW: begin
				s_nxt.gate.p_gate = `AMF_PGATE_OFF;
				s_nxt.gate.n_gate = ~`AMF_NGATE_OFF;
			end
			default: begin
				s_nxt.gate.p_gate = `AMF_PGATE_OFF;
				s_nxt.gate.n_gate = `AMF_NGATE_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r.st <= AMF_HB_OFF;
			s_r.cnt <= '0;
			s_r.gate.p_gate <= `AMF_PGATE_OFF;
			s_r.gate.n_gate <= `AMF_NGATE_OFF;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign gate = s_r.gate;

endmodule
`default_nettype wire

// ---- design/amf_mode_fault_ctrl.sv ----
/*
 * Mode and fault control of a two channel switching amplifier: selects
 * the gate drive of four bridge halves and keeps a latched fault warning.
 * Assumes sleep, mute and sense pins are asynchronous; pwm requests come
 * from the modulator on clk.
 */
//
// Summary of operation
// - Every sense input is a pass or fail condition; high means fail.
// - Sleep low, mute high: temperature fail raises the fault warning.
// - Sleep and mute low: keep switching, temperature fail raises the warning.
// - Running: either left current sense failing raises the warning.
// - Running: either right current sense failing raises the warning.
// - Without any fail outside sleep the warning keeps its previous level.
// - Running: all gates of both channels switch, whatever the warning.
// - Each bridge half gets an interval with both transistors off.
// - Sleep high: all gates off and the warning forced low.
// - Mute high: all gates off and current senses ignored.
// - Only sleep or the asynchronous reset arst_n clears the latched warning.
`timescale 1ns/1ps
`default_nettype none
`include "amf_params.svh"

module amf_mode_fault_ctrl #(
	parameter int CNT_W = `AMF_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Mode pins
	input wire logic sleep,
	input wire logic mute,
	// Sense pins, high means fail
	input wire logic temp_sense_in,
	input wire logic left_pos_current_sense,
	input wire logic left_neg_current_sense,
	input wire logic right_pos_current_sense,
	input wire logic right_neg_current_sense,
	// Modulator requests, high turns the positive-going transistor on
	input wire logic left_pos_pwm,
	input wire logic left_neg_pwm,
	input wire logic right_pos_pwm,
	input wire logic right_neg_pwm,
	// Gate drives
	output logic left_pos_pfet_gate,
	output logic left_pos_nfet_gate,
	output logic left_neg_pfet_gate,
	output logic left_neg_nfet_gate,
	output logic right_pos_pfet_gate,
	output logic right_pos_nfet_gate,
	output logic right_neg_pfet_gate,
	output logic right_neg_nfet_gate,
	// Status
	output logic fault_warning_out,
	output amf_pkg::amf_mode_t mode
);
	import amf_pkg::*;

	// ============================================================
	// Derived timing
	// Least time, so round up, never below one cycle
	localparam int DEAD_RAW = (`AMF_DEAD_TIME_NS + `AMF_CLK_PERIOD_NS - 1) / `AMF_CLK_PERIOD_NS;
	localparam int DEAD_INT = (DEAD_RAW < 1) ? 1 : DEAD_RAW;
	localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'(DEAD_INT);

	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		amf_mode_t mode;
		logic fault;
	} amf_top_reg_t;

	amf_top_reg_t s_r;
	amf_top_reg_t s_nxt;
	amf_sense_t sense;
	logic sleep_s;
	logic mute_s;
	logic enable;
	logic [6:0] pins;
	// Index order: left_pos, left_neg, right_pos, right_neg
	amf_gate_t gates [4];

	// ============================================================
	// Synchronised pin levels
	// Sense bits sit low, in the order of the sense struct
	assign pins = {sleep, mute, temp_sense_in, right_neg_current_sense, right_pos_current_sense,
		left_neg_current_sense, left_pos_current_sense};
	// Second stage only; first stage feeds nothing else
	assign sense = amf_sense_t'(s_r.sync2[4:0]);
	assign mute_s = s_r.sync2[5];
	assign sleep_s = s_r.sync2[6];
	assign enable = (s_r.mode == AMF_MODE_RUN);

	// ============================================================
	// Decoders
	// Sleep outranks mute, mute outranks running
	function automatic amf_mode_t mode_of(input logic slp, input logic mut);
		amf_mode_t m;
		if (slp) begin
			m = AMF_MODE_SLEEP;
		end else if (mut) begin
			m = AMF_MODE_MUTE;
		end else begin
			m = AMF_MODE_RUN;
		end
		return m;
	endfunction

	// Overcurrent only counts while running; gates are off otherwise
	function automatic logic fault_hit(input amf_mode_t m, input amf_sense_t s);
		logic hit;
		case (m)
			AMF_MODE_MUTE: begin
				hit = s.temp;
			end
			AMF_MODE_RUN: begin
				hit = s.temp
					| s.left_pos | s.left_neg
					| s.right_pos | s.right_neg;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	// ============================================================
	// Mode and fault latch
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.mode = mode_of(sleep_s, mute_s);
		case (s_nxt.mode)
			AMF_MODE_SLEEP: begin
				s_nxt.fault = 1'b0;
			end
			default: begin
				// No fail keeps the old level
				s_nxt.fault = s_r.fault | fault_hit(s_nxt.mode, sense);
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r.sync1 <= `AMF_SYNC_RST;
			s_r.sync2 <= `AMF_SYNC_RST;
			s_r.mode <= AMF_MODE_SLEEP;
			s_r.fault <= `AMF_FAULT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ============================================================
	// Bridge halves
	// The warning does not stop switching; an external loop to mute does
	// Left channel, positive side
	amf_half_bridge #(
		.CNT_W(CNT_W),
		.DEAD_CYC(DEAD_CYC)
	) u_half_left_pos (
		.clk(clk),
		.arst_n(arst_n),
		.enable(enable),
		.drive_high_on(left_pos_pwm),
		.gate(gates[0])
	);

	// Left channel, negative side
	amf_half_bridge #(
		.CNT_W(CNT_W),
		.DEAD_CYC(DEAD_CYC)
	) u_half_left_neg (
		.clk(clk),
		.arst_n(arst_n),
		.enable(enable),
		.drive_high_on(left_neg_pwm),
		.gate(gates[1])
	);

	// Right channel, positive side
	amf_half_bridge #(
		.CNT_W(CNT_W),
		.DEAD_CYC(DEAD_CYC)
	) u_half_right_pos (
		.clk(clk),
		.arst_n(arst_n),
		.enable(enable),
		.drive_high_on(right_pos_pwm),
		.gate(gates[2])
	);

	// Right channel, negative side
	amf_half_bridge #(
		.CNT_W(CNT_W),
		.DEAD_CYC(DEAD_CYC)
	) u_half_right_neg (
		.clk(clk),
		.arst_n(arst_n),
		.enable(enable),
		.drive_high_on(right_neg_pwm),
		.gate(gates[3])
	);

	// ============================================================
	// Outputs, all from flip-flops
	assign left_pos_pfet_gate = gates[0].p_gate;
	assign left_pos_nfet_gate = gates[0].n_gate;
	assign left_neg_pfet_gate = gates[1].p_gate;
	assign left_neg_nfet_gate = gates[1].n_gate;
	assign right_pos_pfet_gate = gates[2].p_gate;
	assign right_pos_nfet_gate = gates[2].n_gate;
	assign right_neg_pfet_gate = gates[3].p_gate;
	assign right_neg_nfet_gate = gates[3].n_gate;
	assign fault_warning_out = s_r.fault;
	assign mode = s_r.mode;

endmodule
`default_nettype wire

// ---- tb/amf_bridge_model.sv ----
/* Far side model: four bridge halves with their current sense circuits.
 * Assumes gates in bit order left_pos, left_neg, right_pos, right_neg. */
`timescale 1ns/1ps
`default_nettype none
module amf_bridge_model (
	// Gate drives, low P and high N conduct
	input wire logic [3:0] p_gate,
	input wire logic [3:0] n_gate,
	// Bench commanded load short
	input wire logic [3:0] short_req,
	// Sense outputs, high means fail
	output logic [3:0] cur_fail
);
	// ============================================================
	// Sense
	// Both transistors on shorts the rail and trips the sense
	assign cur_fail = short_req | (~p_gate & n_gate);
endmodule
`default_nettype wire

// ---- tb/amf_mode_fault_ctrl_asserts.sv ----
/* Port checker for amf_mode_fault_ctrl, bound to every instance.
 * Assumes pins pass two sync stages before they take effect. */
`timescale 1ns/1ps
`default_nettype none
module amf_mode_fault_ctrl_asserts
	import amf_pkg::*;
#(
	parameter int CNT_W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Mode and sense pins
	input wire logic sleep,
	input wire logic mute,
	input wire logic temp_sense_in,
	input wire logic left_pos_current_sense,
	input wire logic left_neg_current_sense,
	input wire logic right_pos_current_sense,
	input wire logic right_neg_current_sense,
	// Modulator requests
	input wire logic left_pos_pwm,
	input wire logic left_neg_pwm,
	input wire logic right_pos_pwm,
	input wire logic right_neg_pwm,
	// Gates and status
	input wire logic left_pos_pfet_gate,
	input wire logic left_pos_nfet_gate,
	input wire logic left_neg_pfet_gate,
	input wire logic left_neg_nfet_gate,
	input wire logic right_pos_pfet_gate,
	input wire logic right_pos_nfet_gate,
	input wire logic right_neg_pfet_gate,
	input wire logic right_neg_nfet_gate,
	input wire logic fault_warning_out,
	input wire amf_pkg::amf_mode_t mode
);
	logic [3:0] pv, nv, pw, cur;
	assign pv = {right_neg_pfet_gate, right_pos_pfet_gate, left_neg_pfet_gate, left_pos_pfet_gate};
	assign nv = {right_neg_nfet_gate, right_pos_nfet_gate, left_neg_nfet_gate, left_pos_nfet_gate};
	assign pw = {right_neg_pwm, right_pos_pwm, left_neg_pwm, left_pos_pwm};
	assign cur = {right_neg_current_sense, right_pos_current_sense, left_neg_current_sense, left_pos_current_sense};
	// ============================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence run_steady;
		mode == AMF_MODE_RUN && $stable(pw);
	endsequence
	a_temp_sets: assert property ((temp_sense_in && !sleep) [*3] |=> fault_warning_out)
		else $error("temperature fail not flagged");
	a_left_sets: assert property ((!sleep && !mute && (cur[0] || cur[1])) [*3] |=> fault_warning_out)
		else $error("left overcurrent not flagged");
	a_right_sets: assert property ((!sleep && !mute && (cur[2] || cur[3])) [*3] |=> fault_warning_out)
		else $error("right overcurrent not flagged");
	a_mute_ignores: assert property ((!sleep && mute && !temp_sense_in) ##2 !fault_warning_out |=> !fault_warning_out)
		else $error("warning set while muted");
	a_fault_holds: assert property (!sleep ##2 fault_warning_out |=> fault_warning_out)
		else $error("warning lost outside sleep");
	a_sleep_clears: assert property (sleep [*3] |=> !fault_warning_out && mode == AMF_MODE_SLEEP)
		else $error("sleep did not clear warning");
	a_idle_off: assert property (mode != AMF_MODE_RUN |=> pv == 4'hF && nv == 4'h0)
		else $error("gates on outside run");
	a_dead_gap: assert property (((nv & ~$past(nv) & ~$past(pv))
		| (~pv & $past(pv) & $past(nv)) | (~pv & nv)) == 4'h0)
		else $error("no off interval");
	a_run_follows: assert property (run_steady [*4] |-> pv == ~pw && nv == ~pw)
		else $error("gates do not follow pwm");
endmodule
bind amf_mode_fault_ctrl amf_mode_fault_ctrl_asserts #(.CNT_W(CNT_W)) u_asserts (
	.clk(clk), .arst_n(arst_n), .sleep(sleep), .mute(mute), .temp_sense_in(temp_sense_in),
	.left_pos_current_sense(left_pos_current_sense), .left_neg_current_sense(left_neg_current_sense),
	.right_pos_current_sense(right_pos_current_sense), .right_neg_current_sense(right_neg_current_sense),
	.left_pos_pwm(left_pos_pwm), .left_neg_pwm(left_neg_pwm),
	.right_pos_pwm(right_pos_pwm), .right_neg_pwm(right_neg_pwm),
	.left_pos_pfet_gate(left_pos_pfet_gate), .left_pos_nfet_gate(left_pos_nfet_gate),
	.left_neg_pfet_gate(left_neg_pfet_gate), .left_neg_nfet_gate(left_neg_nfet_gate),
	.right_pos_pfet_gate(right_pos_pfet_gate), .right_pos_nfet_gate(right_pos_nfet_gate),
	.right_neg_pfet_gate(right_neg_pfet_gate), .right_neg_nfet_gate(right_neg_nfet_gate),
	.fault_warning_out(fault_warning_out), .mode(mode)
);
`default_nettype wire

// ---- tb/amf_mode_fault_ctrl_bench.sv ----
/* Bench for amf_mode_fault_ctrl: a table of pin rows, then mid-run reset and
 * fast pwm. Assumes the bridge model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module amf_mode_fault_ctrl_bench;
	import amf_pkg::*;
	// ============================================================
	// Signals
	logic clk = 1'b0, arst_n = 1'b0, sleep = 1'b0, mute = 1'b0, temp_sense_in = 1'b0;
	logic [3:0] pwm = 4'h5, short_req = 4'h0, pv, nv, cur;
	logic left_pos_pwm, left_neg_pwm, right_pos_pwm, right_neg_pwm, fault_warning_out;
	logic left_pos_current_sense, left_neg_current_sense, right_pos_current_sense, right_neg_current_sense;
	logic left_pos_pfet_gate, left_pos_nfet_gate, left_neg_pfet_gate, left_neg_nfet_gate;
	logic right_pos_pfet_gate, right_pos_nfet_gate, right_neg_pfet_gate, right_neg_nfet_gate;
	amf_mode_t mode;
	int fail_count = 0, tests_run = 0;
	// Row: sleep, mute, temp, short[3:0], expected warning
	logic [7:0] rows [17] = '{8'h00, 8'h61, 8'h01, 8'h80, 8'hA0, 8'hC0, 8'h5E, 8'h21, 8'h80,
		8'h03, 8'h80, 8'h05, 8'h80, 8'h09, 8'h80, 8'h11, 8'h01};
	assign {right_neg_pwm, right_pos_pwm, left_neg_pwm, left_pos_pwm} = pwm;
	assign {right_neg_current_sense, right_pos_current_sense, left_neg_current_sense, left_pos_current_sense} = cur;
	assign pv = {right_neg_pfet_gate, right_pos_pfet_gate, left_neg_pfet_gate, left_pos_pfet_gate};
	assign nv = {right_neg_nfet_gate, right_pos_nfet_gate, left_neg_nfet_gate, left_pos_nfet_gate};
	always #50 clk = ~clk;
	amf_mode_fault_ctrl u_amf_mode_fault_ctrl (
		.clk(clk), .arst_n(arst_n), .sleep(sleep), .mute(mute), .temp_sense_in(temp_sense_in),
		.left_pos_current_sense(left_pos_current_sense), .left_neg_current_sense(left_neg_current_sense),
		.right_pos_current_sense(right_pos_current_sense), .right_neg_current_sense(right_neg_current_sense),
		.left_pos_pwm(left_pos_pwm), .left_neg_pwm(left_neg_pwm),
		.right_pos_pwm(right_pos_pwm), .right_neg_pwm(right_neg_pwm),
		.left_pos_pfet_gate(left_pos_pfet_gate), .left_pos_nfet_gate(left_pos_nfet_gate),
		.left_neg_pfet_gate(left_neg_pfet_gate), .left_neg_nfet_gate(left_neg_nfet_gate),
		.right_pos_pfet_gate(right_pos_pfet_gate), .right_pos_nfet_gate(right_pos_nfet_gate),
		.right_neg_pfet_gate(right_neg_pfet_gate), .right_neg_nfet_gate(right_neg_nfet_gate),
		.fault_warning_out(fault_warning_out), .mode(mode)
	);
	amf_bridge_model u_amf_bridge_model (.p_gate(pv), .n_gate(nv), .short_req(short_req), .cur_fail(cur));
	// ============================================================
	// Tasks
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ============================================================
	// Sequence
	initial begin
		logic [1:0] me;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clk);
			{sleep, mute, temp_sense_in, short_req} <= rows[i][7:1];
			repeat (6) @(posedge clk);
			#1;
			me = rows[i][7] ? AMF_MODE_SLEEP : rows[i][6] ? AMF_MODE_MUTE : AMF_MODE_RUN;
			chk("fault", {3'h0, rows[i][0]}, {3'h0, fault_warning_out});
			chk("mode", {2'h0, me}, {2'h0, mode});
			chk("p gates", rows[i][7:6] != 2'h0 ? 4'hF : 4'hA, pv);
			chk("n gates", rows[i][7:6] != 2'h0 ? 4'h0 : 4'hA, nv);
		end
		// Reset in mid-run must drop the latched warning at once
		@(posedge clk);
		arst_n <= 1'b0;
		#1;
		chk("reset fault", 4'h0, {3'h0, fault_warning_out});
		chk("reset p", 4'hF, pv);
		chk("reset n", 4'h0, nv);
		@(posedge clk);
		arst_n <= 1'b1;
		// Toggle every cycle, worst case for overlapping gates
		repeat (8) @(posedge clk);
		repeat (20) begin
			@(posedge clk);
			pwm <= ~pwm;
		end
		@(posedge clk);
		pwm <= 4'h3;
		repeat (5) @(posedge clk);
		#1;
		chk("fast p", 4'hC, pv);
		chk("fast n", 4'hC, nv);
		chk("no short", 4'h0, {3'h0, fault_warning_out});
		close_out();
	end
	// Span well beyond the 157 or so cycles the sequence needs
	initial begin
		repeat (1000) @(posedge clk);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
